// [include/hp_slot_params.svh]
`ifndef HP_SLOT_PARAMS_SVH
`define HP_SLOT_PARAMS_SVH

// Register byte offsets in configuration space.
`define HP_OFS_SLOT_CAP 8'hd4
`define HP_OFS_SLOT_CTRL 8'hd8

// Reset images of the capability and control structs.
`define HP_CAP_RST 30'h0000_0cdf
`define HP_CTRL_RST 13'h01c0

// Capability word fields.
`define HP_CAP_PL_VAL_LSB 7
`define HP_CAP_PL_VAL_MASK 32'h0000_7f80
`define HP_CAP_PL_SCL_MASK 32'h0001_8000
`define HP_CAP_PL_SCL_LSB 15

// Control half-word fields.
`define HP_CTRL_WR_MASK 16'h1fff
`define HP_CTRL_ATTN_MASK 16'h00c0
`define HP_CTRL_PWR_MASK 16'h0300

// Status half-word (upper half of the control dword).
`define HP_STS_W1C_MASK 16'h011f
`define HP_STS_ATTN 0
`define HP_STS_PFAULT 1
`define HP_STS_LATCH_CHG 2
`define HP_STS_PRES_CHG 3
`define HP_STS_CMD_DONE 4
`define HP_STS_LATCH_OPEN 5
`define HP_STS_PRESENT 6
`define HP_STS_DL_CHG 8

`endif

// [include/hp_slot_pkg.sv]
package hp_slot_pkg;

  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } cfg_req_t;

  typedef struct packed {
    logic [12:0] slot_num;
    logic [1:0] pl_scale;
    logic [7:0] pl_value;
    logic hp_capable;
    logic surprise;
    logic pwr_ind_present;
    logic attn_ind_present;
    logic retention_latch_sensor_present;
    logic pwr_ctrl_present;
    logic attn_btn_present;
  } cap_t;

  typedef struct packed {
    logic dl_chg_en;
    logic electromech_lock_ctrl;
    logic power_off;
    logic [1:0] pwr_ind;
    logic [1:0] attn_ind;
    logic hp_int_en;
    logic cmd_done_en;
    logic presence_en;
    logic retention_latch_sensor_en;
    logic pfault_en;
    logic attn_en;
  } ctrl_t;

  typedef struct packed {
    logic attn_pressed;
    logic power_fault;
    logic retention_latch_sensor_changed;
    logic presence_changed;
    logic cmd_done;
    logic retention_latch_sensor_open;
    logic card_present;
  } slot_in_t;

  typedef enum logic [1:0] {
    MSG_POWER_LIMIT,
    MSG_ATTN_IND,
    MSG_PWR_IND
  } msg_kind_t;

  typedef struct packed {
    msg_kind_t kind;
    logic [9:0] payload;
  } msg_t;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } tx_state_t;

endpackage

// [rtl/hot_plug_slot_cap_ctrl_regs.sv]
// Function
// (R1) Capability bits 0-4 are read-only presence flags resetting to one.
// (R2) Capability bit 5 is read-only surprise-removal flag, reset zero.
// (R3) Capability bit 6 is read-only hot-plug capable flag.
// (R4) Bits 14:7 writable power limit, reset 19h; write sends limit message.
// (R5) Bits 16:15 writable power scale, reset 0; write sends limit message.
// (R6) Bits 31:19 read-only slot number reset zero; bits 18:17 reserved.
// (R7) Capability defaults may be overridden by sideband or EEPROM preload.
// (R8) Both registers exist only on downstream ports.
// (R9) Control bits 0-3 are event enables, reset zero.
// (R10) Control bit 4 enables command completed interrupt, reset zero.
// (R11) Control bit 5 is interrupt master enable, reset zero.
// (R12) Bits 7:6 attention indicator, reset 11b; write sends indicator message.
// (R13) Bits 9:8 power indicator, reset 01b; write sends indicator message.
// (R14) Control bit 10 commands slot power: zero on, one off.
// (R15) Control bit 12 enables data link state change notification.
// (R16) Link active status reads one only while link layer is active.
// (R17) Link active change sets a write-one-to-clear flag.
// (R18) Command completion sets a write-one-to-clear flag.
// (R19) Interrupt asserts when master enable and an enabled flag is set.
// (R20) Control bit 11 interlock control is plain read-write, reset zero.
`include "hp_slot_params.svh"
`timescale 1ns/1ps
`default_nettype none

module hot_plug_slot_cap_ctrl_regs #(
  parameter int IS_DOWNSTREAM = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Configuration access.
  input wire hp_slot_pkg::cfg_req_t i_cfg,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  // Capability preload from sideband or EEPROM.
  input wire logic i_preload_valid,
  input wire hp_slot_pkg::cap_t i_preload,
  // Slot hardware and link layer.
  input wire hp_slot_pkg::slot_in_t i_slot,
  input wire logic i_dl_active,
  // Register state seen by the port.
  output hp_slot_pkg::cap_t o_cap,
  output hp_slot_pkg::ctrl_t o_ctrl,
  output logic o_dl_active,
  output logic o_hp_irq,
  // Message request to the transmit path.
  output logic o_msg_valid,
  output hp_slot_pkg::msg_t o_msg,
  input wire logic i_msg_ready
);

  generate
    if (IS_DOWNSTREAM != 0 && IS_DOWNSTREAM != 1)
    begin : g_chk
      $error("IS_DOWNSTREAM must be 0 or 1");
    end
  endgenerate

  function automatic logic dword_hit(input logic [7:0] a,
                                     input logic [7:0] ofs);
    dword_hit = (a[7:2] == ofs[7:2]);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    lane_mask = m;
  endfunction

  // An upstream port decodes nothing, so both registers read as zero.
  localparam logic PRESENT = (IS_DOWNSTREAM == 1);

  hp_slot_pkg::cap_t cap_reg;
  hp_slot_pkg::cap_t cap_next;
  hp_slot_pkg::ctrl_t ctrl_reg;
  hp_slot_pkg::ctrl_t ctrl_next;
  logic [15:0] sts_reg;
  logic [15:0] sts_next;
  logic dl_active_reg;
  logic irq_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [2:0] pend_reg;
  logic [2:0] pend_next;
  hp_slot_pkg::tx_state_t tx_reg;
  hp_slot_pkg::tx_state_t tx_next;
  hp_slot_pkg::msg_t msg_reg;
  hp_slot_pkg::msg_t msg_next;
  logic [2:0] take;

  wire [31:0] wmask = lane_mask(i_cfg.be);
  wire cap_sel = PRESENT && dword_hit(i_cfg.addr, `HP_OFS_SLOT_CAP); // see (R8)
  wire ctrl_sel = PRESENT && dword_hit(i_cfg.addr, `HP_OFS_SLOT_CTRL); // see (R8)
  wire cap_wr = i_cfg.req && i_cfg.we && cap_sel;
  wire ctrl_wr = i_cfg.req && i_cfg.we && ctrl_sel;

  // Reserved capability bits 18:17 are never stored and read as zero.
  wire [31:0] cap_word = {cap_reg.slot_num, 2'b00, cap_reg.pl_scale,
                          cap_reg.pl_value, cap_reg.hp_capable,
                          cap_reg.surprise, cap_reg.pwr_ind_present,
                          cap_reg.attn_ind_present,
                          cap_reg.retention_latch_sensor_present,
                          cap_reg.pwr_ctrl_present,
                          cap_reg.attn_btn_present}; // see (R1) (R2) (R3) (R6)

  // Only the power limit fields take software writes.
  wire [31:0] pl_mask = `HP_CAP_PL_VAL_MASK | `HP_CAP_PL_SCL_MASK;
  wire [31:0] cap_wmask = wmask & pl_mask;
  wire [31:0] cap_wr_word = (cap_word & ~cap_wmask) |
                            (i_cfg.wdata & cap_wmask); // see (R4) (R5)
  wire pl_touch = cap_wr && (|cap_wmask); // see (R4) (R5)

  // Control half: every defined bit is plain read-write.
  wire [15:0] ctrl_word = {3'b000, ctrl_reg};
  wire [15:0] ctrl_wmask = wmask[15:0] & `HP_CTRL_WR_MASK;
  wire [15:0] ctrl_wr_word = (ctrl_word & ~ctrl_wmask) |
                             (i_cfg.wdata[15:0] & ctrl_wmask); // see (R20)
  wire attn_touch = ctrl_wr && (|(ctrl_wmask & `HP_CTRL_ATTN_MASK)); // see (R12)
  wire pwr_touch = ctrl_wr && (|(ctrl_wmask & `HP_CTRL_PWR_MASK)); // see (R13)

  // Status half: hardware sets, software writes one to clear; bits 5 and 6 are live and cannot be cleared.
  wire dl_change = (dl_active_reg != i_dl_active); // see (R17)
  wire [15:0] sts_set = PRESENT ?
    ((16'(i_slot.attn_pressed) << `HP_STS_ATTN) |
     (16'(i_slot.power_fault) << `HP_STS_PFAULT) |
     (16'(i_slot.retention_latch_sensor_changed) << `HP_STS_LATCH_CHG) |
     (16'(i_slot.presence_changed) << `HP_STS_PRES_CHG) |
     (16'(i_slot.cmd_done) << `HP_STS_CMD_DONE) | // see (R18)
     (16'(dl_change) << `HP_STS_DL_CHG)) // see (R17)
    : 16'h0000;
  wire [15:0] sts_clr = ctrl_wr ?
    (i_cfg.wdata[31:16] & wmask[31:16] & `HP_STS_W1C_MASK) : 16'h0000;
  wire [15:0] sts_live =
    (16'(i_slot.retention_latch_sensor_open) << `HP_STS_LATCH_OPEN) |
    (16'(i_slot.card_present) << `HP_STS_PRESENT);

  // Enables laid over the flags they gate.
  wire [15:0] en_sts =
    (16'(ctrl_reg.attn_en) << `HP_STS_ATTN) |
    (16'(ctrl_reg.pfault_en) << `HP_STS_PFAULT) |
    (16'(ctrl_reg.retention_latch_sensor_en) << `HP_STS_LATCH_CHG) |
    (16'(ctrl_reg.presence_en) << `HP_STS_PRES_CHG) |
    (16'(ctrl_reg.cmd_done_en) << `HP_STS_CMD_DONE) |
    (16'(ctrl_reg.dl_chg_en) << `HP_STS_DL_CHG); // see (R9) (R10) (R15)
  wire irq_next = PRESENT && ctrl_reg.hp_int_en &&
                  (|(sts_reg & en_sts)); // see (R11) (R19)

  // Preload replaces the whole capability image, including software fields.
  always_comb
  begin
    cap_next = cap_reg;
    if (i_preload_valid)
    begin
      cap_next = i_preload; // see (R7)
    end
    else if (pl_touch)
    begin
      cap_next.pl_value = cap_wr_word[`HP_CAP_PL_VAL_LSB +: 8]; // see (R4)
      cap_next.pl_scale = cap_wr_word[`HP_CAP_PL_SCL_LSB +: 2]; // see (R5)
    end
  end

  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (ctrl_wr)
    begin
      ctrl_next = hp_slot_pkg::ctrl_t'(ctrl_wr_word[12:0]); // see (R9) (R14)
    end
  end

  // The set term is ORed last so an event in the clearing cycle survives.
  assign sts_next = (sts_reg & ~sts_clr) | sts_set; // see (R17) (R18)

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (i_cfg.req && !i_cfg.we)
    begin
      if (cap_sel)
      begin
        rdata_next = cap_word;
      end
      else if (ctrl_sel)
      begin
        rdata_next = {sts_reg | sts_live, ctrl_word};
      end
    end
  end

  // Messages wait in pending bits; a rewrite before sending merges.
  always_comb
  begin
    tx_next = tx_reg;
    msg_next = msg_reg;
    take = 3'b000;
    unique case (tx_reg)
      hp_slot_pkg::TX_IDLE:
      begin
        if (pend_reg[0])
        begin
          take = 3'b001;
          msg_next.kind = hp_slot_pkg::MSG_POWER_LIMIT;
          msg_next.payload = {cap_reg.pl_scale, cap_reg.pl_value};
          tx_next = hp_slot_pkg::TX_SEND;
        end
        else if (pend_reg[1])
        begin
          take = 3'b010;
          msg_next.kind = hp_slot_pkg::MSG_ATTN_IND;
          msg_next.payload = {8'h00, ctrl_reg.attn_ind};
          tx_next = hp_slot_pkg::TX_SEND;
        end
        else if (pend_reg[2])
        begin
          take = 3'b100;
          msg_next.kind = hp_slot_pkg::MSG_PWR_IND;
          msg_next.payload = {8'h00, ctrl_reg.pwr_ind};
          tx_next = hp_slot_pkg::TX_SEND;
        end
      end
      hp_slot_pkg::TX_SEND:
      begin
        if (i_msg_ready)
        begin
          tx_next = hp_slot_pkg::TX_IDLE;
        end
      end
    endcase
  end

  assign pend_next = (pend_reg & ~take) |
                     {pwr_touch, attn_touch, pl_touch}; // see (R4) (R12) (R13)

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cap_reg <= hp_slot_pkg::cap_t'(`HP_CAP_RST); // see (R1) (R2) (R4)
      ctrl_reg <= hp_slot_pkg::ctrl_t'(`HP_CTRL_RST); // see (R12) (R13)
      sts_reg <= 16'h0000;
    end
    else
    begin
      cap_reg <= cap_next;
      ctrl_reg <= ctrl_next;
      sts_reg <= sts_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      dl_active_reg <= 1'b0;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      dl_active_reg <= i_dl_active; // see (R16)
      irq_reg <= irq_next;
      ack_reg <= i_cfg.req;
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pend_reg <= 3'b000;
      tx_reg <= hp_slot_pkg::TX_IDLE;
      msg_reg <= '0;
    end
    else
    begin
      pend_reg <= pend_next;
      tx_reg <= tx_next;
      msg_reg <= msg_next;
    end
  end

  assign o_cfg_ack = ack_reg;
  assign o_cfg_rdata = rdata_reg;
  assign o_cap = cap_reg;
  assign o_ctrl = ctrl_reg; // see (R14)
  assign o_dl_active = dl_active_reg; // see (R16)
  assign o_hp_irq = irq_reg; // see (R19)
  assign o_msg_valid = (tx_reg == hp_slot_pkg::TX_SEND);
  assign o_msg = msg_reg;

endmodule

`default_nettype wire

// [test/hp_slot_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module hp_slot_chk (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Watched ports.
  input wire hp_slot_pkg::cfg_req_t i_cfg,
  input wire logic o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic i_preload_valid,
  input wire hp_slot_pkg::cap_t o_cap,
  input wire hp_slot_pkg::ctrl_t o_ctrl,
  input wire logic i_dl_active,
  input wire logic o_dl_active,
  input wire logic o_hp_irq,
  input wire logic o_msg_valid,
  input wire hp_slot_pkg::msg_t o_msg,
  input wire logic i_msg_ready
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  wire wr = i_cfg.req && i_cfg.we;
  a_ack_req: assert property (i_cfg.req |=> o_cfg_ack)
    else $error("ack missing after request");
  a_ack_idle: assert property (!i_cfg.req |=> !o_cfg_ack)
    else $error("ack without request");
  a_wr_rdata_zero: assert property (wr |=> o_cfg_rdata == 32'h0000_0000)
    else $error("read data not zero after write");
  a_cap_ro_stable: assert property (
    !i_preload_valid |=> $stable({o_cap.slot_num, o_cap[6:0]}))
    else $error("read-only capability field changed");
  a_limit_msg: assert property (
    wr && i_cfg.addr == 8'hd4 &&
    |i_cfg.be[2:0] |-> ##[2:40] o_msg_valid &&
    o_msg.kind == hp_slot_pkg::MSG_POWER_LIMIT)
    else $error("power limit message not sent");
  a_attn_write: assert property (
    wr && i_cfg.addr == 8'hd8 &&
    i_cfg.be[0] |=> o_ctrl.attn_ind == $past(i_cfg.wdata[7:6]))
    else $error("attention field not written");
  a_power_write: assert property (
    wr && i_cfg.addr == 8'hd8 &&
    i_cfg.be[1] |=> o_ctrl.power_off == $past(i_cfg.wdata[10]))
    else $error("power control not written");
  a_irq_master: assert property (
    !o_ctrl.hp_int_en |=> !o_hp_irq)
    else $error("interrupt while master enable clear");
  a_msg_hold: assert property (o_msg_valid && !i_msg_ready |=>
    o_msg_valid && $stable(o_msg))
    else $error("message dropped before ready");
  a_msg_gap: assert property (o_msg_valid && i_msg_ready |=> !o_msg_valid)
    else $error("no idle cycle after message");
  a_dl_copy: assert property (!$past(i_rst) |->
    o_dl_active == $past(i_dl_active))
    else $error("link active status wrong");
  c_msg_sent: cover property (o_msg_valid && i_msg_ready);
  c_irq: cover property (o_hp_irq);
  c_preload: cover property (i_preload_valid);
endmodule
bind hot_plug_slot_cap_ctrl_regs hp_slot_chk chk (.i_clk, .i_rst, .i_cfg,
  .o_cfg_ack, .o_cfg_rdata, .i_preload_valid, .o_cap, .o_ctrl, .i_dl_active,
  .o_dl_active, .o_hp_irq, .o_msg_valid, .o_msg, .i_msg_ready);
`default_nettype wire

// [test/hp_msg_sink.sv]
`timescale 1ns/1ps
`default_nettype none
module hp_msg_sink (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Message request from the port.
  input wire logic i_valid,
  input wire hp_slot_pkg::msg_t i_msg,
  // Handshake and record of what was taken.
  output logic o_ready,
  output logic [15:0] o_count,
  output hp_slot_pkg::msg_t o_last
);
  // Random stalls make the port hold a message for several cycles.
  initial o_ready = 1'b0;
  always @(negedge i_clk) o_ready <= ($urandom % 3) != 0;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_count <= 16'h0000;
    else if (i_valid && o_ready)
    begin
      o_count <= o_count + 16'h0001;
      o_last <= i_msg;
    end
  end
endmodule
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  hp_slot_pkg::cfg_req_t i_cfg = '0;
  logic i_preload_valid = 1'b0;
  hp_slot_pkg::cap_t i_preload = '0;
  hp_slot_pkg::slot_in_t i_slot = '0;
  logic i_dl_active = 1'b0;
  logic o_cfg_ack, o_dl_active, o_hp_irq, o_msg_valid, i_msg_ready;
  logic [31:0] o_cfg_rdata, w, r, capx;
  hp_slot_pkg::cap_t o_cap;
  hp_slot_pkg::ctrl_t o_ctrl;
  hp_slot_pkg::msg_t o_msg, last;
  logic [15:0] cnt, t;
  logic [3:0] be;
  int n_fail = 0, compares = 0, cyc = 0;
  hot_plug_slot_cap_ctrl_regs dut (.i_clk, .i_rst, .i_cfg, .o_cfg_ack,
    .o_cfg_rdata, .i_preload_valid, .i_preload, .i_slot, .i_dl_active,
    .o_cap, .o_ctrl, .o_dl_active, .o_hp_irq, .o_msg_valid, .o_msg,
    .i_msg_ready);
  hp_msg_sink sink (.i_clk, .i_rst, .i_valid(o_msg_valid), .i_msg(o_msg),
    .o_ready(i_msg_ready), .o_count(cnt), .o_last(last));
  initial forever #20 i_clk = ~i_clk;
  task give_verdict();
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      $display("unexpected %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask
  task cfg(input logic we, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    @(negedge i_clk);
    i_cfg = '{1'b1, we, a, b, d};
    @(negedge i_clk);
    i_cfg.req = 1'b0;
    chk("ack", o_cfg_ack, 1);
    r = o_cfg_rdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    cfg(1'b0, a, 4'h0, 32'h0000_0000);
    chk("read data", r, e);
  endtask
  task msg(input logic [15:0] tgt, input logic [11:0] e);
    for (int i = 0; i < 40 && cnt != tgt; i++) @(negedge i_clk);
    chk("message count", cnt, tgt);
    chk("message", last, e);
  endtask
  // Slot events are one-cycle pulses; the extra cycle lets the irq land.
  task pulse(input logic [6:0] e);
    @(negedge i_clk);
    i_slot = e;
    @(negedge i_clk);
    i_slot = '0;
    @(negedge i_clk);
  endtask
  function automatic logic [31:0] exp_cap(logic [31:0] c, logic [31:0] d,
    logic [3:0] b);
    logic [31:0] mk;
    mk = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h0001_ff80;
    return (c & ~mk) | (d & mk);
  endfunction
  initial
  begin
    void'($urandom(47));
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    rdc(8'hd4, 32'h0000_0cdf);
    rdc(8'hd8, 32'h0000_01c0);
    chk("control", r, 32'h0000_01c0);
    cfg(1'b1, 8'hdc, 4'hf, 32'hffff_ffff);
    rdc(8'hdc, 32'h0000_0000);
    cfg(1'b1, 8'hd4, 4'h8, 32'hffff_ffff);
    rdc(8'hd4, 32'h0000_0cdf);
    capx = 32'h0000_0cdf;
    repeat (10)
    begin
      w = $urandom;
      be = 4'($urandom);
      t = cnt + 16'h0001;
      cfg(1'b1, 8'hd4, be, w);
      capx = exp_cap(capx, w, be);
      if (|be[2:0])
        msg(t, {hp_slot_pkg::MSG_POWER_LIMIT, capx[16:7]});
      rdc(8'hd4, capx);
    end
    for (int k = 0; k < 4; k++)
    begin
      w = $urandom;
      w[7:6] = 2'(k);
      w[9:8] = 2'(3 - k);
      t = cnt + 16'h0001;
      cfg(1'b1, 8'hd8, 4'h1, w);
      msg(t, {hp_slot_pkg::MSG_ATTN_IND, 8'h00, w[7:6]});
      t = cnt + 16'h0001;
      cfg(1'b1, 8'hd8, 4'h2, w);
      msg(t, {hp_slot_pkg::MSG_PWR_IND, 8'h00, w[9:8]});
      rdc(8'hd8, {19'h0_0000, w[12:0]});
    end
    cfg(1'b1, 8'hd8, 4'h3, 32'h0000_01f0);
    pulse(7'b000_0100);
    chk("irq", o_hp_irq, 1);
    rdc(8'hd8, 32'h0010_01f0);
    cfg(1'b1, 8'hd8, 4'h4, 32'h0010_0000);
    rdc(8'hd8, 32'h0000_01f0);
    chk("irq", o_hp_irq, 0);
    for (int i = 0; i < 4; i++)
    begin
      cfg(1'b1, 8'hd8, 4'h1, 32'h0000_00e0 | (32'h1 << i));
      pulse(7'b100_0000 >> i);
      chk("irq", o_hp_irq, 1);
      cfg(1'b1, 8'hd8, 4'h4, 32'h0001_0000 << i);
      rdc(8'hd8, 32'h0000_01e0 | (32'h1 << i));
    end
    cfg(1'b1, 8'hd8, 4'h1, 32'h0000_00df);
    pulse(7'b111_1100);
    chk("irq", o_hp_irq, 0);
    i_dl_active = 1'b1;
    i_slot = 7'b000_0011;
    repeat (2) @(negedge i_clk);
    chk("link active", o_dl_active, 1);
    rdc(8'hd8, 32'h017f_01df);
    w = $urandom;
    i_preload = w[29:0];
    i_preload_valid = 1'b1;
    @(negedge i_clk);
    i_preload_valid = 1'b0;
    chk("capability", o_cap, i_preload);
    rdc(8'hd4, {i_preload[29:17], 2'b00, i_preload[16:0]});
    give_verdict();
  end
endmodule
`default_nettype wire
